// *** dagm_pkg.sv ***
// dagm_pkg: offsets, field positions and reset values shared by the address
// generators, the memory map decode and the register slave.
// assumes a single core clock and a 32-bit AHB-Lite register bus.
package dagm_pkg;
  // register byte offsets; haddr[8] picks the generator for offsets below 0x200
  localparam logic [11:0] OFS_GEN_STRIDE = 12'h0100;
  localparam logic [11:0] OFS_PTR = 12'h0000;
  localparam logic [11:0] OFS_MOD = 12'h0010;
  localparam logic [11:0] OFS_LEN = 12'h0020;
  localparam logic [11:0] OFS_BASE = 12'h0030;
  localparam logic [11:0] OFS_PAGE = 12'h0040;
  localparam logic [11:0] OFS_CTX = 12'h0044;
  localparam logic [11:0] OFS_BANK_START = 12'h0200;
  localparam logic [11:0] OFS_BANK_CFG = 12'h0210;
  localparam logic [11:0] OFS_EXT_CTRL = 12'h0220;
  localparam logic [11:0] OFS_DM_LAST = 12'h0228;
  localparam logic [11:0] OFS_PM_LAST = 12'h022C;
  // generator register index kinds
  localparam logic [2:0] KIND_PTR = 3'h0;
  localparam logic [2:0] KIND_MOD = 3'h1;
  localparam logic [2:0] KIND_LEN = 3'h2;
  localparam logic [2:0] KIND_BASE = 3'h3;
  localparam logic [2:0] KIND_MISC = 3'h4;
  // field positions
  localparam int unsigned BANK_WAIT_LSB = 0;
  localparam int unsigned BANK_MODE_BIT = 4;
  localparam int unsigned EXT_W8_BIT = 0;
  localparam int unsigned EXT_PACK_BIT = 1;
  localparam int unsigned IO_PAGE_LSB = 10;
  // memory map
  localparam logic [7:0] PAGE_RAM = 8'h00;
  localparam logic [7:0] PAGE_BOOT = 8'hFF;
  localparam logic [7:0] PAGE_EXT_LAST = 8'hFE;
  localparam logic [15:0] RAM1_BASE = 16'h4000;
  localparam logic [15:0] RAM2_BASE = 16'h8000;
  localparam logic [15:0] RAM_END = 16'hA000;
  localparam logic [15:0] ROM_BASE = 16'hF000;
  localparam logic [7:0] IO_ONCHIP_PAGES = 8'h20;
  // reset values
  localparam logic [7:0] RST_BANK0_START = 8'h01;
  localparam logic [7:0] RST_BANK1_START = 8'h40;
  localparam logic [7:0] RST_BANK2_START = 8'h80;
  localparam logic [7:0] RST_BANK3_START = 8'hC0;
  localparam logic [4:0] RST_BANK_CFG = 5'h00;
  localparam logic [1:0] RST_EXT_CTRL = 2'h0;
endpackage

// *** dagm_addr_gen.sv ***
// dagm_addr_gen: one data address generator with two register sets,
// pre/post modify and circular wrap inside one 64K-word page.
// assumes bus writes and core accesses arrive on sys_clk.
`timescale 1ns/1ps
module dagm_addr_gen (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // core access
  input wire logic acc_en,
  input wire logic [1:0] ptr_sel,
  input wire logic [1:0] mod_sel,
  input wire logic pre_mod,
  // register port
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [4:0] rd_idx,
  output logic [15:0] rd_data,
  // result
  output logic [23:0] addr,
  output logic ctx
);
  logic [15:0] ptr_q [2][4];
  logic [15:0] mod_q [2][4];
  logic [15:0] len_q [2][4];
  logic [15:0] base_q [2][4];
  logic [7:0] page_q [2];
  logic [15:0] cur, m, len, base, sum, off, next_ptr;
  logic wr_ptr;

  assign wr_ptr = wr_en && (wr_idx[4:2] == dagm_pkg::KIND_PTR);

  always_comb begin
    cur = ptr_q[ctx][ptr_sel];
    m = mod_q[ctx][mod_sel];
    len = len_q[ctx][ptr_sel];
    base = base_q[ctx][ptr_sel];
    sum = cur + m; // 16-bit sum, no carry into the page
    off = sum - base;
    next_ptr = sum;
    if (len != 16'h0000 && off >= len) begin
      next_ptr = m[15] ? sum + len : sum - len;
    end
    addr = {page_q[ctx], pre_mod ? next_ptr : cur};
  end

  // pointer update on use; a bus write to a pointer wins over the core
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < 4; i++) begin
          ptr_q[s][i] <= 16'h0000;
        end
      end
    end else if (wr_ptr) begin
      ptr_q[ctx][wr_idx[1:0]] <= wr_data;
    end else if (acc_en) begin
      ptr_q[ctx][ptr_sel] <= next_ptr;
    end
  end

  // modify, length, base and page: bus writes land in the active set
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < 2; s++) begin
        page_q[s] <= 8'h00;
        for (int i = 0; i < 4; i++) begin
          mod_q[s][i] <= 16'h0000;
          len_q[s][i] <= 16'h0000;
          base_q[s][i] <= 16'h0000;
        end
      end
    end else if (wr_en) begin
      unique case (wr_idx[4:2])
        dagm_pkg::KIND_MOD: mod_q[ctx][wr_idx[1:0]] <= wr_data;
        dagm_pkg::KIND_LEN: len_q[ctx][wr_idx[1:0]] <= wr_data;
        dagm_pkg::KIND_BASE: base_q[ctx][wr_idx[1:0]] <= wr_data;
        dagm_pkg::KIND_MISC: begin
          if (wr_idx[1:0] == 2'h0) begin
            page_q[ctx] <= wr_data[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // set select: only an index flips, nothing is copied
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctx <= 1'b0;
    end else if (wr_en && wr_idx == {dagm_pkg::KIND_MISC, 2'h1}) begin
      ctx <= wr_data[0];
    end
  end

  always_comb begin
    rd_data = 16'h0000;
    unique case (rd_idx[4:2])
      dagm_pkg::KIND_PTR: rd_data = ptr_q[ctx][rd_idx[1:0]];
      dagm_pkg::KIND_MOD: rd_data = mod_q[ctx][rd_idx[1:0]];
      dagm_pkg::KIND_LEN: rd_data = len_q[ctx][rd_idx[1:0]];
      dagm_pkg::KIND_BASE: rd_data = base_q[ctx][rd_idx[1:0]];
      dagm_pkg::KIND_MISC: begin
        rd_data = (rd_idx[1:0] == 2'h0) ? {8'h00, page_q[ctx]} : {15'h0000, ctx};
      end
      default: rd_data = 16'h0000;
    endcase
  end

  a_ptr_update: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (acc_en && !wr_ptr && !(wr_en && wr_idx[4:2] == dagm_pkg::KIND_MISC))
      |=> ptr_q[ctx][$past(ptr_sel)] == $past(next_ptr))
    else $error("used pointer not updated");

  a_circ_stays_in: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (acc_en && len != 16'h0000 && (cur - base) < len && (m < len || -m < len))
      |-> (16'(next_ptr - base) < len))
    else $error("circular pointer left its buffer");
endmodule

// *** dagm_top.sv ***
// dagm_top: two address generators, paged memory map decode, external bus
// multiplexer and an AHB-Lite register slave.
// assumes the core drives access requests on sys_clk; one slave on the bus.
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - four 16-bit pointers, updated on each use
// - pre- or post-modify by one modify register
// - length and base give circular addressing
// - circular buffers never carry into page
// - secondary set switched without copying values
// - two generators work independently each cycle
// - upper eight bits select one of 256 pages
// - page 0 holds three on-chip RAM blocks
// - boot ROM tops page 255, pages 1-254 off-chip
// - four external banks, own select, programmable
// - I/O pages 0-31 on-chip, higher assert select
// - both buses share one external bus
// - twenty address lines, width and packing dependent
// - program and data operand in one cycle, except both off-chip (pm_ext_stall)
// - per-generator page register supplies upper byte
// - reset bank boundaries 1, 64, 128, 192
module dagm_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // data memory operand request (generator 0)
  input wire logic dm_acc,
  input wire logic dm_wr,
  input wire logic [1:0] dm_ptr_sel,
  input wire logic [1:0] dm_mod_sel,
  input wire logic dm_pre_mod,
  input wire logic [15:0] data_mem_data_bus,
  // program memory operand request (generator 1)
  input wire logic pm_acc,
  input wire logic pm_wr,
  input wire logic [1:0] pm_ptr_sel,
  input wire logic [1:0] pm_mod_sel,
  input wire logic pm_pre_mod,
  input wire logic [23:0] prog_mem_data_bus,
  // I/O space request
  input wire logic io_req,
  input wire logic io_wr,
  input wire logic [17:0] io_addr,
  // decoded addresses and on-chip selects
  output logic [23:0] data_mem_addr_bus,
  output logic [23:0] prog_mem_addr_bus,
  output logic [2:0] dm_ram_sel,
  output logic [2:0] pm_ram_sel,
  output logic dm_rom_sel,
  output logic pm_rom_sel,
  output logic io_cfg_sel,
  output logic pm_ext_stall,
  // shared external port
  output logic [19:0] ext_addr,
  output logic [15:0] ext_wdata,
  output logic ext_rd,
  output logic ext_wr,
  output logic [3:0] ext_bank_select_n,
  output logic io_space_select_n,
  output logic [3:0] ext_wait_count,
  output logic ext_wait_mode
);
  logic [1:0] acc, pre, wr_en;
  logic [1:0] psel [2];
  logic [1:0] msel [2];
  logic [15:0] gen_rd [2];
  logic [23:0] gen_addr [2];
  logic [1:0] gen_ctx;
  logic [7:0] bank_start [4];
  logic [4:0] bank_cfg [4];
  logic [1:0] ext_ctrl;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic addr_ph;
  logic [31:0] next_rdata;
  logic [8:0] dm_dec, pm_dec;
  logic [19:0] dm_phys, pm_phys;
  logic io_ext;

  assign acc = {pm_acc, dm_acc};
  assign pre = {pm_pre_mod, dm_pre_mod};
  assign psel[0] = dm_ptr_sel;
  assign psel[1] = pm_ptr_sel;
  assign msel[0] = dm_mod_sel;
  assign msel[1] = pm_mod_sel;
  assign addr_ph = hsel && htrans[1] && hready;
  assign io_ext = io_req && (io_addr[17:dagm_pkg::IO_PAGE_LSB] >= dagm_pkg::IO_ONCHIP_PAGES);

  // one generator feeds the data bus, the other the program bus
  for (genvar g = 0; g < 2; g++) begin : g_gen
    assign wr_en[g] = wr_pend && wr_addr[11:9] == 3'h0 && wr_addr[8] == 1'(g)
                      && wr_addr[7:0] <= dagm_pkg::OFS_CTX[7:0];
    dagm_addr_gen u_gen (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .acc_en(acc[g]),
      .ptr_sel(psel[g]),
      .mod_sel(msel[g]),
      .pre_mod(pre[g]),
      .wr_en(wr_en[g]),
      .wr_idx(wr_addr[6:2]),
      .wr_data(hwdata[15:0]),
      .rd_idx(haddr[6:2]),
      .rd_data(gen_rd[g]),
      .addr(gen_addr[g]),
      .ctx(gen_ctx[g])
    );
  end

  // map decode: [2:0] ram block, [3] rom, [7:4] bank one-hot, [8] off-chip
  function automatic logic [8:0] decode(input logic [23:0] a, input logic [7:0] s1,
                                        input logic [7:0] s2, input logic [7:0] s3);
    logic [7:0] pg;
    logic [15:0] o;
    pg = a[23:16];
    o = a[15:0];
    decode = 9'h000;
    if (pg == dagm_pkg::PAGE_RAM) begin
      if (o < dagm_pkg::RAM1_BASE) decode[0] = 1'b1;
      else if (o < dagm_pkg::RAM2_BASE) decode[1] = 1'b1;
      else if (o < dagm_pkg::RAM_END) decode[2] = 1'b1;
    end else if (pg == dagm_pkg::PAGE_BOOT) begin
      decode[3] = (o >= dagm_pkg::ROM_BASE);
    end else begin
      decode[8] = 1'b1;
      if (pg >= s3) decode[7] = 1'b1;
      else if (pg >= s2) decode[6] = 1'b1;
      else if (pg >= s1) decode[5] = 1'b1;
      else decode[4] = 1'b1;
    end
  endfunction

  // word address to physical address on twenty lines
  function automatic logic [19:0] phys(input logic [23:0] a, input logic [1:0] c);
    phys = (c[dagm_pkg::EXT_W8_BIT] && c[dagm_pkg::EXT_PACK_BIT]) ? {a[18:0], 1'b0} : a[19:0];
  endfunction

  always_comb begin
    dm_dec = acc[0] ? decode(gen_addr[0], bank_start[1], bank_start[2], bank_start[3]) : 9'h000;
    pm_dec = acc[1] ? decode(gen_addr[1], bank_start[1], bank_start[2], bank_start[3]) : 9'h000;
    dm_phys = phys(gen_addr[0], ext_ctrl);
    pm_phys = phys(gen_addr[1], ext_ctrl);
  end

  // on-chip address buses and selects
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_mem_addr_bus <= 24'h00_0000;
      prog_mem_addr_bus <= 24'h00_0000;
      dm_ram_sel <= 3'h0;
      pm_ram_sel <= 3'h0;
      dm_rom_sel <= 1'b0;
      pm_rom_sel <= 1'b0;
      io_cfg_sel <= 1'b0;
    end else begin
      if (acc[0]) data_mem_addr_bus <= gen_addr[0];
      if (acc[1]) prog_mem_addr_bus <= gen_addr[1];
      dm_ram_sel <= dm_dec[2:0];
      pm_ram_sel <= pm_dec[2:0];
      dm_rom_sel <= dm_dec[3];
      pm_rom_sel <= pm_dec[3];
      io_cfg_sel <= io_req && !io_ext;
    end
  end

  // shared external port: data operand first, then program operand, then I/O
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_addr <= 20'h0_0000;
      ext_wdata <= 16'h0000;
      ext_rd <= 1'b0;
      ext_wr <= 1'b0;
      ext_bank_select_n <= 4'hF;
      io_space_select_n <= 1'b1;
      ext_wait_count <= 4'h0;
      ext_wait_mode <= 1'b0;
      pm_ext_stall <= 1'b0;
    end else begin
      ext_rd <= 1'b0;
      ext_wr <= 1'b0;
      ext_bank_select_n <= 4'hF;
      io_space_select_n <= 1'b1;
      pm_ext_stall <= dm_dec[8] && pm_dec[8];
      if (dm_dec[8]) begin
        ext_addr <= dm_phys;
        ext_wdata <= data_mem_data_bus;
        ext_rd <= !dm_wr;
        ext_wr <= dm_wr;
        ext_bank_select_n <= ~dm_dec[7:4];
      end else if (pm_dec[8]) begin
        ext_addr <= pm_phys;
        ext_wdata <= prog_mem_data_bus[15:0];
        ext_rd <= !pm_wr;
        ext_wr <= pm_wr;
        ext_bank_select_n <= ~pm_dec[7:4];
      end else if (io_ext) begin
        ext_addr <= {2'b00, io_addr};
        ext_wdata <= data_mem_data_bus;
        ext_rd <= !io_wr;
        ext_wr <= io_wr;
        io_space_select_n <= 1'b0;
      end
      for (int b = 0; b < 4; b++) begin
        if (dm_dec[8] ? dm_dec[4 + b] : pm_dec[4 + b]) begin
          ext_wait_count <= bank_cfg[b][dagm_pkg::BANK_WAIT_LSB +: 4];
          ext_wait_mode <= bank_cfg[b][dagm_pkg::BANK_MODE_BIT];
        end
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_ph && hwrite;
      if (addr_ph) wr_addr <= haddr[11:0];
      if (addr_ph && !hwrite) hrdata <= next_rdata;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr[11:9] == 3'h0 && haddr[7:0] <= dagm_pkg::OFS_CTX[7:0]) begin
      next_rdata = {16'h0000, gen_rd[haddr[8]]};
    end else if (haddr[11:4] == dagm_pkg::OFS_BANK_START[11:4]) begin
      next_rdata = {24'h00_0000, bank_start[haddr[3:2]]};
    end else if (haddr[11:4] == dagm_pkg::OFS_BANK_CFG[11:4]) begin
      next_rdata = {27'h000_0000, bank_cfg[haddr[3:2]]};
    end else if (haddr[11:0] == dagm_pkg::OFS_EXT_CTRL) begin
      next_rdata = {30'h0000_0000, ext_ctrl};
    end else if (haddr[11:0] == dagm_pkg::OFS_DM_LAST) begin
      next_rdata = {8'h00, data_mem_addr_bus};
    end else if (haddr[11:0] == dagm_pkg::OFS_PM_LAST) begin
      next_rdata = {8'h00, prog_mem_addr_bus};
    end
  end

  // bank boundaries and timing; bank 0 always starts at page 1
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_start[0] <= dagm_pkg::RST_BANK0_START;
      bank_start[1] <= dagm_pkg::RST_BANK1_START;
      bank_start[2] <= dagm_pkg::RST_BANK2_START;
      bank_start[3] <= dagm_pkg::RST_BANK3_START;
      for (int b = 0; b < 4; b++) bank_cfg[b] <= dagm_pkg::RST_BANK_CFG;
      ext_ctrl <= dagm_pkg::RST_EXT_CTRL;
    end else if (wr_pend) begin
      if (wr_addr[11:4] == dagm_pkg::OFS_BANK_START[11:4] && wr_addr[3:2] != 2'h0) begin
        bank_start[wr_addr[3:2]] <= hwdata[7:0];
      end
      if (wr_addr[11:4] == dagm_pkg::OFS_BANK_CFG[11:4]) begin
        bank_cfg[wr_addr[3:2]] <= hwdata[4:0];
      end
      if (wr_addr == dagm_pkg::OFS_EXT_CTRL) ext_ctrl <= hwdata[1:0];
    end
  end

  a_ram_block0: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (dm_acc && gen_addr[0][23:16] == 8'h00 && gen_addr[0][15:0] < dagm_pkg::RAM1_BASE)
      |=> (dm_ram_sel == 3'b001 && ext_bank_select_n[0] == $past(!pm_dec[4])))
    else $error("page 0 low address missed RAM block 0");

  a_rom_top: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pm_acc && gen_addr[1][23:12] == 12'hFFF) |=> pm_rom_sel && pm_ram_sel == 3'h0)
    else $error("top of page 255 did not select boot ROM");

  a_bank_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (dm_acc && gen_addr[0][23:16] == 8'h40 && bank_start[1] == 8'h40 && bank_start[2] == 8'h80)
      |=> ext_bank_select_n == 4'b1101 && ext_rd != ext_wr)
    else $error("page 64 did not select bank 1");

  a_io_split: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (io_req && !dm_dec[8] && !pm_dec[8])
      |=> (io_cfg_sel == ($past(io_addr[17:10]) < 8'h20)) && (io_space_select_n == io_cfg_sel))
    else $error("I/O page decode wrong");

  a_ext_pack: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (dm_dec[8] && ext_ctrl == 2'b11) |=> ext_addr == {$past(gen_addr[0][18:0]), 1'b0})
    else $error("packed byte address not doubled");

  a_ext_prio: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (dm_dec[8] && pm_dec[8]) |=> pm_ext_stall && ext_bank_select_n == ~$past(dm_dec[7:4]))
    else $error("program operand conflict not flagged");

  a_bus_okay: assert property (@(posedge sys_clk) disable iff (!arst_n)
    hreadyout && !hresp)
    else $error("bus slave not ready or not OKAY");
endmodule

// *** dagm_ext_mem.sv ***
// dagm_ext_mem: far-side memory on the shared external port.
// assumes one-cycle active-high strobes from the block, captured at the next edge.
`timescale 1ns/1ps
module dagm_ext_mem (
  // clock
  input wire logic sys_clk,
  // external port
  input wire logic [15:0] ext_wdata,
  input wire logic ext_wr,
  // observation
  output logic [15:0] last_wdata
);
  initial begin
    last_wdata = 16'h0000;
  end
  // data, program and I/O writes all arrive on the one shared port
  always @(posedge sys_clk) begin
    if (ext_wr) begin
      last_wdata <= ext_wdata;
    end
  end
endmodule

// *** test_data_address_gen_memory_map.sv ***
// test_data_address_gen_memory_map: directed bench for generators and memory map decode.
// assumes dagm_top as the only AHB-Lite slave and dagm_ext_mem on its external port.
`timescale 1ns/1ps
module test_data_address_gen_memory_map;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, dm_rom_sel, pm_rom_sel, io_cfg_sel, pm_ext_stall, ext_rd, ext_wr;
  logic io_space_select_n, ext_wait_mode;
  logic [31:0] hrdata;
  logic [23:0] data_mem_addr_bus, prog_mem_addr_bus;
  logic [2:0] dm_ram_sel, pm_ram_sel;
  logic [19:0] ext_addr;
  logic [15:0] ext_wdata, last_wdata;
  logic [3:0] ext_bank_select_n, ext_wait_count;
  logic dm_acc = 1'b0, pm_acc = 1'b0, dm_wr = 1'b0, pm_wr = 1'b0, pre = 1'b0;
  logic io_req = 1'b0, io_wr = 1'b0;
  logic [1:0] dsel = 2'h0, psel = 2'h0;
  logic [15:0] dm_dat = 16'h0000;
  logic [23:0] pm_dat = 24'h00_0000;
  logic [17:0] io_addr = 18'h0_0000;
  logic [7:0] st [4] = '{8'h01, 8'h40, 8'h80, 8'hC0};
  logic [7:0] pgs [8] = '{8'h01, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFE};
  int fails = 0, checks = 0, cyc = 0;

  dagm_top u_dagm_top (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .dm_acc(dm_acc), .dm_wr(dm_wr), .dm_ptr_sel(dsel),
    .dm_mod_sel(dsel), .dm_pre_mod(pre), .data_mem_data_bus(dm_dat), .pm_acc(pm_acc),
    .pm_wr(pm_wr), .pm_ptr_sel(psel), .pm_mod_sel(psel), .pm_pre_mod(pre),
    .prog_mem_data_bus(pm_dat), .io_req(io_req), .io_wr(io_wr), .io_addr(io_addr),
    .data_mem_addr_bus(data_mem_addr_bus), .prog_mem_addr_bus(prog_mem_addr_bus),
    .dm_ram_sel(dm_ram_sel), .pm_ram_sel(pm_ram_sel), .dm_rom_sel(dm_rom_sel),
    .pm_rom_sel(pm_rom_sel), .io_cfg_sel(io_cfg_sel), .pm_ext_stall(pm_ext_stall),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rd(ext_rd), .ext_wr(ext_wr),
    .ext_bank_select_n(ext_bank_select_n), .io_space_select_n(io_space_select_n),
    .ext_wait_count(ext_wait_count), .ext_wait_mode(ext_wait_mode)
  );
  dagm_ext_mem u_dagm_ext_mem (
    .sys_clk(sys_clk), .ext_wdata(ext_wdata), .ext_wr(ext_wr), .last_wdata(last_wdata)
  );

  always #4 sys_clk = ~sys_clk;

  task automatic end_sim;
    $display("TB: checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single AHB-Lite word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(n, e, x);
  endtask

  function automatic logic [31:0] ga(input int g, input logic [11:0] ofs, input int i);
    return 32'(g * 256) + 32'(ofs) + 32'(i * 4);
  endfunction

  task automatic setg(input int g, input int i, input logic [7:0] pg, input logic [15:0] p,
      input logic [15:0] m, input logic [15:0] l, input logic [15:0] b);
    wr(ga(g, dagm_pkg::OFS_PAGE, 0), 32'(pg));
    wr(ga(g, dagm_pkg::OFS_MOD, i), 32'(m));
    wr(ga(g, dagm_pkg::OFS_LEN, i), 32'(l));
    wr(ga(g, dagm_pkg::OFS_BASE, i), 32'(b));
    wr(ga(g, dagm_pkg::OFS_PTR, i), 32'(p));
  endtask

  // one core access; results are settled one nanosecond after the taking edge
  task automatic acc(input logic d, input logic p, input logic [1:0] ds, input logic [1:0] ps,
      input logic pr, input logic w);
    @(posedge sys_clk);
    dm_acc <= d;
    pm_acc <= p;
    dsel <= ds;
    psel <= ps;
    pre <= pr;
    dm_wr <= w;
    pm_wr <= w;
    @(posedge sys_clk);
    dm_acc <= 1'b0;
    pm_acc <= 1'b0;
    #1;
  endtask

  task automatic step(input int g, input logic [1:0] i, input logic pr, input logic [23:0] e);
    acc(g == 0, g == 1, i, i, pr, 1'b0);
    chk("addr", 32'(e), g == 0 ? 32'(data_mem_addr_bus) : 32'(prog_mem_addr_bus));
  endtask

  task automatic place(input int g, input logic [7:0] pg, input logic [15:0] p);
    wr(ga(g, dagm_pkg::OFS_PAGE, 0), 32'(pg));
    wr(ga(g, dagm_pkg::OFS_PTR, 3), 32'(p));
    acc(g == 0, g == 1, 2'h3, 2'h3, 1'b0, 1'b0);
  endtask

  task automatic io(input logic [17:0] a, input logic w);
    @(posedge sys_clk);
    io_req <= 1'b1;
    io_addr <= a;
    io_wr <= w;
    @(posedge sys_clk);
    io_req <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int b = 0; b < 4; b++) rdc("start", 32'h0000_0200 + 32'(b * 4), 32'(st[b]));
    rdc("unmapped", 32'h0000_0300, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, 32'(hresp));
    setg(0, 0, 8'h00, 16'h3FFF, 16'h0001, 16'h0000, 16'h0000);
    step(0, 2'h0, 1'b0, 24'h00_3FFF);
    chk("ram0", 32'h0000_0001, 32'(dm_ram_sel));
    step(0, 2'h0, 1'b0, 24'h00_4000);
    chk("ram1", 32'h0000_0002, 32'(dm_ram_sel));
    rdc("ptr", ga(0, dagm_pkg::OFS_PTR, 0), 32'h0000_4001);
    setg(0, 1, 8'h00, 16'h9FFE, 16'h0001, 16'h0000, 16'h0000);
    step(0, 2'h1, 1'b1, 24'h00_9FFF);
    chk("ram2", 32'h0000_0004, 32'(dm_ram_sel));
    step(0, 2'h1, 1'b1, 24'h00_A000);
    chk("hole", 32'h0000_000F, {dm_ram_sel, dm_rom_sel, ext_bank_select_n});
    setg(1, 0, 8'h00, 16'h0010, 16'h0001, 16'h0000, 16'h0000);
    acc(1'b1, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0);
    chk("dual dm", 32'h0000_4001, 32'(data_mem_addr_bus));
    chk("dual pm", 32'h0000_0010, 32'(prog_mem_addr_bus));
    chk("dual sel", 32'h0000_0011, {26'h000_0000, dm_ram_sel, pm_ram_sel});
    wr(ga(0, dagm_pkg::OFS_CTX, 0), 32'h0000_0001);
    wr(ga(0, dagm_pkg::OFS_PTR, 0), 32'h0000_2222);
    rdc("second", ga(0, dagm_pkg::OFS_PTR, 0), 32'h0000_2222);
    wr(ga(0, dagm_pkg::OFS_CTX, 0), 32'h0000_0000);
    rdc("primary", ga(0, dagm_pkg::OFS_PTR, 0), 32'h0000_4002);
    setg(1, 2, 8'h00, 16'h8003, 16'h0001, 16'h0004, 16'h8000);
    step(1, 2'h2, 1'b0, 24'h00_8003);
    step(1, 2'h2, 1'b0, 24'h00_8000);
    wr(ga(1, dagm_pkg::OFS_MOD, 2), 32'h0000_FFFE);
    step(1, 2'h2, 1'b0, 24'h00_8001);
    step(1, 2'h2, 1'b0, 24'h00_8003);
    setg(1, 1, 8'h07, 16'hFFFF, 16'h0001, 16'h0004, 16'hFFFC);
    step(1, 2'h1, 1'b0, 24'h07_FFFF);
    step(1, 2'h1, 1'b0, 24'h07_FFFC);
    setg(0, 2, 8'h05, 16'hFFFF, 16'h0001, 16'h0000, 16'h0000);
    step(0, 2'h2, 1'b0, 24'h05_FFFF);
    step(0, 2'h2, 1'b0, 24'h05_0000);
    setg(0, 3, 8'h00, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    setg(1, 3, 8'h00, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      place(0, pgs[k], 16'h1234);
      chk("bank", 32'(4'hF ^ (4'h1 << (k / 2))), 32'(ext_bank_select_n));
      chk("rd", 32'h0000_0001, 32'(ext_rd));
    end
    wr(32'h0000_0200, 32'h0000_0009);
    rdc("bank0 fixed", 32'h0000_0200, 32'h0000_0001);
    wr(32'h0000_0208, 32'h0000_0050);
    wr(32'h0000_0214, 32'h0000_0015);
    rdc("cfg", 32'h0000_0214, 32'h0000_0015);
    place(0, 8'h4F, 16'h0000);
    chk("wait", 32'h0000_01B5, {ext_bank_select_n, ext_wait_mode, ext_wait_count});
    place(0, 8'h50, 16'h0000);
    chk("moved", 32'h0000_000B, 32'(ext_bank_select_n));
    place(1, 8'hFF, 16'hF000);
    chk("rom", 32'h0000_001F, {pm_rom_sel, ext_bank_select_n});
    place(0, 8'hFF, 16'hEFFF);
    chk("no rom", 32'h0000_000F, {dm_rom_sel, ext_bank_select_n});
    wr(32'h0000_0220, 32'h0000_0003);
    place(0, 8'h01, 16'h0100);
    chk("packed", 32'h0002_0200, 32'(ext_addr));
    wr(32'h0000_0220, 32'h0000_0001);
    place(0, 8'h01, 16'h0100);
    chk("word", 32'h0001_0100, 32'(ext_addr));
    dm_dat <= 16'hA5C3;
    pm_dat <= 24'h12_3456;
    wr(ga(1, dagm_pkg::OFS_PAGE, 0), 32'h0000_0040);
    acc(1'b1, 1'b1, 2'h3, 2'h3, 1'b0, 1'b1);
    chk("stall", 32'h0000_003E, {pm_ext_stall, ext_wr, ext_bank_select_n});
    @(posedge sys_clk);
    #1;
    chk("far wdata", 32'h0000_A5C3, 32'(last_wdata));
    acc(1'b0, 1'b1, 2'h3, 2'h3, 1'b0, 1'b1);
    chk("pm wdata", 32'h000D_3456, {12'h000, ext_bank_select_n, ext_wdata});
    io(18'h0_7C00, 1'b0);
    chk("io cfg", 32'h0000_0003, 32'({io_cfg_sel, io_space_select_n}));
    io(18'h0_8000, 1'b1);
    chk("io ext", 32'h0000_8000, 32'({io_cfg_sel, io_space_select_n, ext_addr}));
    end_sim();
  end
endmodule
